// ---- src/phyc_pkg.sv ----
package phyc_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [4:0] PHYC_ADDR_CTRL = 5'h10;
  localparam logic [4:0] PHYC_ADDR_STAT = 5'h11;
  localparam logic [4:0] PHYC_ADDR_INTST = 5'h12;
  localparam logic [4:0] PHYC_ADDR_INTMSK = 5'h13;
  localparam logic [4:0] PHYC_ADDR_CMD = 5'h14;
  // ****************
  // field positions
  // ****************
  localparam int PHYC_XOVER_LO = 5;
  localparam int PHYC_CLKOFF_BIT = 4;
  localparam int PHYC_MACPWR_BIT = 3;
  localparam int PHYC_SQE_BIT = 2;
  localparam int PHYC_POLDIS_BIT = 1;
  localparam int PHYC_JABDIS_BIT = 0;
  localparam int PHYC_CMD_SWRST_BIT = 15;
  localparam int PHYC_CMD_ANEN_BIT = 12;
  localparam int PHYC_CMD_PWRDN_BIT = 11;
  localparam int PHYC_INT_PAGE = 0;
  localparam int PHYC_INT_LINK = 1;
  localparam int PHYC_INT_DSHIFT = 2;
  localparam logic [6:0] PHYC_CTRL_WMASK = 7'h7f;
  localparam logic [2:0] PHYC_INT_WMASK = 3'h7;
  // ****************
  // encodings and reset values
  // ****************
  typedef enum logic [1:0] {
    PHYC_XO_MDI = 2'h0,
    PHYC_XO_MDIX = 2'h1,
    PHYC_XO_RSVD = 2'h2,
    PHYC_XO_AUTO = 2'h3
  } phyc_xover_t;
  localparam logic [1:0] PHYC_SPD_10 = 2'h0;
  localparam logic [1:0] PHYC_SPD_100 = 2'h1;
  localparam logic [1:0] PHYC_SPD_1000 = 2'h2;
  localparam logic [3:0] PHYC_MODE_A = 4'h7;
  localparam logic [3:0] PHYC_MODE_B = 4'h3;
  localparam logic PHYC_MACPWR_RST = 1'h1;
  localparam logic PHYC_SQE_RST = 1'h0;
  localparam logic PHYC_POLDIS_RST = 1'h0;
  localparam logic PHYC_JABDIS_RST = 1'h0;
  localparam logic PHYC_ANEN_RST = 1'h1;
  localparam logic [15:0] PHYC_ZERO16 = 16'h0000;
endpackage : phyc_pkg

// ---- src/phyc_pwr.sv ----
`timescale 1ns/1ps
`default_nettype none
module phyc_pwr
  import phyc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_off,
  input wire logic mac_keep_up,
  input wire logic pwr_down,
  input wire logic energy_sleep,
  input wire logic [3:0] if_mode,
  output logic ref_clock_out,
  output logic mac_pwr_down,
  output logic rx_clk_stop
);
  // ****************
  // power state
  // ****************
  typedef enum logic [1:0] {
    PHYC_PS_ACTIVE = 2'h0,
    PHYC_PS_SLEEP = 2'h1,
    PHYC_PS_DOWN = 2'h3
  } phyc_pstate_t;
  phyc_pstate_t ps_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ps_reg <= PHYC_PS_ACTIVE;
    end else begin
      case (1'b1)
        pwr_down: ps_reg <= PHYC_PS_DOWN;
        energy_sleep: ps_reg <= PHYC_PS_SLEEP;
        default: ps_reg <= PHYC_PS_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_clock_out <= 1'b0;
    end else begin
      // held low when disabled, free toggle otherwise
      ref_clock_out <= clk_off ? 1'b0 : ~ref_clock_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mac_pwr_down <= 1'b0;
      rx_clk_stop <= 1'b0;
    end else begin
      mac_pwr_down <= !mac_keep_up && (ps_reg != PHYC_PS_ACTIVE);
      rx_clk_stop <= (ps_reg == PHYC_PS_DOWN)
        && (if_mode == PHYC_MODE_A || if_mode == PHYC_MODE_B);
    end
  end

  refclk_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_off ##1 clk_off |=> !ref_clock_out)
    else $error("reference clock not held low");
  refclk_tog_a: assert property (@(posedge clk) disable iff (!rst_b)
    !clk_off ##1 !clk_off |=> ref_clock_out != $past(ref_clock_out))
    else $error("reference clock not toggling");
  mac_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    mac_keep_up |=> !mac_pwr_down)
    else $error("mac interface powered down while kept up");
  rxclk_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pwr_down && if_mode == PHYC_MODE_A) ##1 (pwr_down && if_mode == PHYC_MODE_A)
    |=> rx_clk_stop)
    else $error("receive clock not stopped in power down");
endmodule : phyc_pwr
`default_nettype wire

// ---- src/phyc_regs.sv ----
// Notes on behaviour
// - crossover field 00 is straight, 01 crossed, 10 reserved, 11 automatic in all modes.
// - crossover, clock-off and mac power writes act only after a software reset.
// - hardware reset loads crossover 11 from straps, else 01 multi-port or 00 single-port.
// - clock-off bit resets from its strap; 1 holds the reference output low, 0 toggles it.
// - mac power bit resets to 1 keeping the mac side up; 0 lets it drop in power-down.
// - in power-down with interface mode 0111 or 0011 the receive clock is stopped.
// - sqe test follows its bit, reset 0, but is always off in full duplex.
// - polarity disable bit forces normal polarity in 10 Mb/s; 0 allows reversal.
// - jabber disable bit turns jabber off; jabber works only in 10 Mb/s half duplex.
// - speed reads 10 for 1000, 01 for 100, 00 for 10, valid once resolved.
// - duplex reads 1 full and 0 half, valid once resolved.
// - resolved sets on negotiation done, is 1 with negotiation off, 0 while blocked.
// - page received latches high until the status register is read or a software reset clears it.
// - cable length code reports 000 to 100 by distance band in 1000 mode.
// - crossover status is 1 crossed, 0 straight; manual mode mirrors the active field.
`timescale 1ns/1ps
`default_nettype none
module phyc_regs
  import phyc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic IRQ,
  input wire logic CROSSOVER_STRAP,
  input wire logic [3:0] NEGOTIATION_STRAP,
  input wire logic REFCLK_OFF_STRAP,
  input wire logic MULTI_PORT_STRAP,
  input wire logic AN_COMPLETE,
  input wire logic AN_BLOCKED,
  input wire logic PAGE_RX,
  input wire logic LINK_UP,
  input wire logic [1:0] SPEED_IN,
  input wire logic DUPLEX_IN,
  input wire logic [2:0] CABLE_LEN_IN,
  input wire logic MDIX_RESOLVED,
  input wire logic DOWNSHIFT_IN,
  input wire logic ENERGY_SLEEP,
  input wire logic [3:0] IF_MODE,
  output logic REF_CLOCK_OUT,
  output logic MAC_PWR_DOWN,
  output logic RX_CLK_STOP,
  output logic MDIX_ACTIVE,
  output logic AUTO_XOVER,
  output logic SQE_EN,
  output logic POL_REV_ALLOW,
  output logic JABBER_EN
);
  import phyc_pkg::*;

  // ****************
  // decode helpers
  // ****************
  function automatic logic [1:0] xover_default(input logic xs, input logic [3:0] ns,
                                               input logic mp);
    if (xs && ns[3]) begin
      xover_default = PHYC_XO_AUTO;
    end else begin
      xover_default = mp ? PHYC_XO_MDIX : PHYC_XO_MDI;
    end
  endfunction : xover_default

  function automatic logic is_wr(input logic wr, input logic [4:0] a, input logic [4:0] t);
    is_wr = wr && (a == t);
  endfunction : is_wr

  // ****************
  // control register, written value and active copy
  // ****************
  logic [1:0] xover_reg;
  logic clk_off_reg;
  logic mac_up_reg;
  logic sqe_reg;
  logic pol_dis_reg;
  logic jab_dis_reg;
  logic [1:0] act_xover_reg;
  logic act_clk_off_reg;
  logic act_mac_up_reg;
  logic an_en_reg;
  logic pwr_dn_reg;
  logic sw_rst_reg;
  logic ctrl_wr;
  logic cmd_wr;

  assign ctrl_wr = is_wr(WR, ADDR, PHYC_ADDR_CTRL);
  assign cmd_wr = is_wr(WR, ADDR, PHYC_ADDR_CMD);

  // reset branch is synchronous, so the straps are sampled by a clocked process
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      xover_reg <= xover_default(CROSSOVER_STRAP, NEGOTIATION_STRAP, MULTI_PORT_STRAP);
      clk_off_reg <= REFCLK_OFF_STRAP;
      mac_up_reg <= PHYC_MACPWR_RST;
      sqe_reg <= PHYC_SQE_RST;
      pol_dis_reg <= PHYC_POLDIS_RST;
      jab_dis_reg <= PHYC_JABDIS_RST;
    end else if (ctrl_wr) begin
      xover_reg <= WDATA[PHYC_XOVER_LO +: 2];
      clk_off_reg <= WDATA[PHYC_CLKOFF_BIT];
      mac_up_reg <= WDATA[PHYC_MACPWR_BIT];
      sqe_reg <= WDATA[PHYC_SQE_BIT];
      pol_dis_reg <= WDATA[PHYC_POLDIS_BIT];
      jab_dis_reg <= WDATA[PHYC_JABDIS_BIT];
    end
  end

  // disruptive controls reach the logic only through a software reset
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      act_xover_reg <= xover_default(CROSSOVER_STRAP, NEGOTIATION_STRAP, MULTI_PORT_STRAP);
      act_clk_off_reg <= REFCLK_OFF_STRAP;
      act_mac_up_reg <= PHYC_MACPWR_RST;
    end else if (sw_rst_reg) begin
      act_xover_reg <= xover_reg;
      act_clk_off_reg <= clk_off_reg;
      act_mac_up_reg <= mac_up_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      an_en_reg <= PHYC_ANEN_RST;
      pwr_dn_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
    end else begin
      sw_rst_reg <= cmd_wr && WDATA[PHYC_CMD_SWRST_BIT];
      if (cmd_wr) begin
        an_en_reg <= WDATA[PHYC_CMD_ANEN_BIT];
        pwr_dn_reg <= WDATA[PHYC_CMD_PWRDN_BIT];
      end
    end
  end

  // ****************
  // status register
  // ****************
  logic [1:0] speed_reg;
  logic duplex_reg;
  logic page_reg;
  logic resolved_reg;
  logic link_reg;
  logic [2:0] cable_reg;
  logic mdix_st_reg;
  logic dshift_reg;
  logic resolved_next;
  logic stat_rd;
  logic [15:0] stat_word;

  assign stat_rd = RD && (ADDR == PHYC_ADDR_STAT);
  assign resolved_next = !AN_BLOCKED && (!an_en_reg || AN_COMPLETE);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      resolved_reg <= 1'b0;
      link_reg <= 1'b0;
      cable_reg <= 3'h0;
      dshift_reg <= 1'b0;
      mdix_st_reg <= 1'b0;
    end else begin
      resolved_reg <= resolved_next;
      link_reg <= LINK_UP;
      // outside 1000 mode the estimate has no meaning, so it reads zero
      cable_reg <= (SPEED_IN == PHYC_SPD_1000) ? CABLE_LEN_IN : 3'h0;
      dshift_reg <= DOWNSHIFT_IN;
      if (act_xover_reg == PHYC_XO_AUTO) begin
        mdix_st_reg <= resolved_next && MDIX_RESOLVED;
      end else begin
        mdix_st_reg <= resolved_next && act_xover_reg[0];
      end
    end
  end

  // speed and duplex keep their last resolved value across a software reset
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      speed_reg <= PHYC_SPD_10;
      duplex_reg <= 1'b0;
    end else if (resolved_next) begin
      speed_reg <= SPEED_IN;
      duplex_reg <= DUPLEX_IN;
    end
  end

  // a page arriving in the clearing read cycle is kept
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      page_reg <= 1'b0;
    end else if (PAGE_RX) begin
      page_reg <= 1'b1;
    end else if (stat_rd || sw_rst_reg) begin
      page_reg <= 1'b0;
    end
  end

  assign stat_word = {speed_reg, duplex_reg, page_reg, resolved_reg, link_reg,
                      cable_reg, mdix_st_reg, dshift_reg, 5'h00};

  // ****************
  // interrupts
  // ****************
  logic [2:0] int_st_reg;
  logic [2:0] int_mask_reg;
  logic [2:0] int_ev;
  logic link_q_reg;
  logic dshift_q_reg;
  logic [2:0] int_clr;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      // track the pins during reset, so release shows no false change or rise
      link_q_reg <= LINK_UP;
      dshift_q_reg <= DOWNSHIFT_IN;
    end else begin
      link_q_reg <= LINK_UP;
      dshift_q_reg <= DOWNSHIFT_IN;
    end
  end

  assign int_ev = {DOWNSHIFT_IN && !dshift_q_reg, LINK_UP != link_q_reg, PAGE_RX};
  assign int_clr = is_wr(WR, ADDR, PHYC_ADDR_INTST) ? WDATA[2:0] & PHYC_INT_WMASK : 3'h0;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      int_st_reg <= 3'h0;
      int_mask_reg <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      // set wins over a write-one clear in the same cycle
      int_st_reg <= (int_st_reg & ~int_clr) | int_ev;
      if (is_wr(WR, ADDR, PHYC_ADDR_INTMSK)) begin
        int_mask_reg <= WDATA[2:0];
      end
      IRQ <= |(int_st_reg & int_mask_reg);
    end
  end

  // ****************
  // read port
  // ****************
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= PHYC_ZERO16;
    end else if (RD) begin
      case (ADDR)
        PHYC_ADDR_CTRL: RDATA <= {9'h000, xover_reg, clk_off_reg, mac_up_reg,
                                  sqe_reg, pol_dis_reg, jab_dis_reg};
        PHYC_ADDR_STAT: RDATA <= stat_word;
        PHYC_ADDR_INTST: RDATA <= {13'h0000, int_st_reg};
        PHYC_ADDR_INTMSK: RDATA <= {13'h0000, int_mask_reg};
        PHYC_ADDR_CMD: RDATA <= {3'h0, an_en_reg, pwr_dn_reg, 11'h000};
        default: RDATA <= PHYC_ZERO16;
      endcase
    end else begin
      RDATA <= PHYC_ZERO16;
    end
  end

  // ****************
  // operating controls
  // ****************
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      MDIX_ACTIVE <= 1'b0;
      AUTO_XOVER <= 1'b0;
      SQE_EN <= 1'b0;
      POL_REV_ALLOW <= 1'b1;
      JABBER_EN <= 1'b0;
    end else begin
      AUTO_XOVER <= (act_xover_reg == PHYC_XO_AUTO);
      case (act_xover_reg)
        PHYC_XO_MDI: MDIX_ACTIVE <= 1'b0;
        PHYC_XO_MDIX: MDIX_ACTIVE <= 1'b1;
        PHYC_XO_AUTO: MDIX_ACTIVE <= MDIX_RESOLVED;
        default: MDIX_ACTIVE <= MDIX_ACTIVE;
      endcase
      SQE_EN <= sqe_reg && !DUPLEX_IN;
      POL_REV_ALLOW <= !(pol_dis_reg && SPEED_IN == PHYC_SPD_10);
      JABBER_EN <= !jab_dis_reg && SPEED_IN == PHYC_SPD_10 && !DUPLEX_IN;
    end
  end

  phyc_pwr u_pwr (
    .clk(CLK),
    .rst_b(RST_B),
    .clk_off(act_clk_off_reg),
    .mac_keep_up(act_mac_up_reg),
    .pwr_down(pwr_dn_reg),
    .energy_sleep(ENERGY_SLEEP),
    .if_mode(IF_MODE),
    .ref_clock_out(REF_CLOCK_OUT),
    .mac_pwr_down(MAC_PWR_DOWN),
    .rx_clk_stop(RX_CLK_STOP)
  );

  // ****************
  // checks
  // ****************
  xover_auto_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(RST_B) |-> AUTO_XOVER == ($past(act_xover_reg) == PHYC_XO_AUTO))
    else $error("auto crossover does not follow active field");
  sw_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !sw_rst_reg |=> $stable(act_xover_reg) && $stable(act_mac_up_reg))
    else $error("active control changed without software reset");
  strap_load_a: assert property (@(posedge CLK)
    !RST_B && CROSSOVER_STRAP && NEGOTIATION_STRAP[3] |=> act_xover_reg == PHYC_XO_AUTO)
    else $error("crossover strap default wrong");
  sqe_fd_a: assert property (@(posedge CLK) disable iff (!RST_B)
    DUPLEX_IN |=> !SQE_EN)
    else $error("sqe test on in full duplex");
  jab_a: assert property (@(posedge CLK) disable iff (!RST_B)
    SPEED_IN != PHYC_SPD_10 |=> !JABBER_EN)
    else $error("jabber enabled outside 10 Mb/s");
  blocked_a: assert property (@(posedge CLK) disable iff (!RST_B)
    AN_BLOCKED |=> !resolved_reg)
    else $error("resolved set while blocked");
  an_off_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !an_en_reg && !AN_BLOCKED |=> resolved_reg)
    else $error("resolved clear with negotiation off");
  page_clr_a: assert property (@(posedge CLK) disable iff (!RST_B)
    stat_rd && !PAGE_RX |=> !page_reg)
    else $error("page flag not cleared by read");
  page_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    PAGE_RX |=> page_reg)
    else $error("page flag not latched");
  mdix_man_a: assert property (@(posedge CLK) disable iff (!RST_B)
    act_xover_reg == PHYC_XO_MDIX |=> MDIX_ACTIVE)
    else $error("manual crossed wiring not applied");
  pol_force_a: assert property (@(posedge CLK) disable iff (!RST_B)
    pol_dis_reg && SPEED_IN == PHYC_SPD_10 |=> !POL_REV_ALLOW)
    else $error("polarity reversal allowed while disabled");
  speed_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !resolved_next |=> $stable(speed_reg) && $stable(duplex_reg))
    else $error("speed or duplex changed while unresolved");
  cable_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
    SPEED_IN != PHYC_SPD_1000 |=> cable_reg == 3'h0)
    else $error("cable estimate outside 1000 mode");
  xover_stat_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !resolved_next |=> !mdix_st_reg)
    else $error("crossover status set before resolution");
endmodule : phyc_regs
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phyc_pkg::*;
  // ****************
  // stimulus and model state
  // ****************
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, cs = 0, rco = 0, mp = 0, anc = 0, blk = 0;
  logic pg = 0, link = 0, dup = 0, mdix = 0, ds = 0, es = 0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] neg = 4'h0, ifm = 4'h0;
  logic [1:0] spd = 2'h0;
  logic [2:0] cab = 3'h0;
  logic [15:0] rdata, d;
  logic irq, ref_o, macpd, rxstop, mdxa, autox, sqe, polr, jab, r0, mx, anen, m_dup;
  logic [6:0] ctrl, act;
  logic [1:0] m_spd = 2'h0;
  logic [31:0] v;
  int seed = 32'h10f52826;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  phyc_regs DUT (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .CROSSOVER_STRAP(cs), .NEGOTIATION_STRAP(neg),
    .REFCLK_OFF_STRAP(rco), .MULTI_PORT_STRAP(mp), .AN_COMPLETE(anc), .AN_BLOCKED(blk),
    .PAGE_RX(pg), .LINK_UP(link), .SPEED_IN(spd), .DUPLEX_IN(dup), .CABLE_LEN_IN(cab),
    .MDIX_RESOLVED(mdix), .DOWNSHIFT_IN(ds), .ENERGY_SLEEP(es), .IF_MODE(ifm),
    .REF_CLOCK_OUT(ref_o), .MAC_PWR_DOWN(macpd), .RX_CLK_STOP(rxstop), .MDIX_ACTIVE(mdxa),
    .AUTO_XOVER(autox), .SQE_EN(sqe), .POL_REV_ALLOW(polr), .JABBER_EN(jab));

  always #20 clk = ~clk;

  // the whole run needs about 600 cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ****************
  // shared tasks
  // ****************
  task automatic finish_test();
    $display("mismatches %0d of %0d compares", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : bus_rd

  // a software reset copies the written controls into the working copy
  task automatic sw_reset(input logic [15:0] cmd);
    bus_wr(PHYC_ADDR_CMD, cmd);
    if (ctrl[6:5] != 2'h2) mx = ctrl[5];
    act = ctrl;
    cyc(5);
  endtask : sw_reset

  task automatic hw_reset(input logic [3:0] s);
    logic [1:0] xo;
    xo = (s[0] & s[1]) ? 2'h3 : {1'b0, s[2]};
    @(posedge clk);
    cs <= s[0];
    neg <= {s[1], 3'($random(seed))};
    mp <= s[2];
    rco <= s[3];
    rst_b <= 1'b0;
    repeat (15) @(posedge clk);
    #1 check(polr, 1'b1);
    check(rdata, 16'h0000);
    ctrl = {xo, s[3], 4'h8};
    act = ctrl;
    mx = xo[0];
    anen = 1'b1;
    @(posedge clk);
    rst_b <= 1'b1;
  endtask : hw_reset

  function automatic logic exp_mdx();
    return (act[6:5] == 2'h3) ? mdix : mx;
  endfunction : exp_mdx

  function automatic logic [15:0] st_exp();
    logic res;
    res = ~blk & (~anen | anc);
    if (res) begin
      m_spd = spd;
      m_dup = dup;
    end
    return {m_spd, m_dup, 1'b0, res, link, (spd == 2'h2) ? cab : 3'h0,
      res & ((act[6:5] == 2'h3) ? mdix : act[5]), ds, 5'h00};
  endfunction : st_exp

  // ****************
  // main sequence
  // ****************
  initial begin
    for (int i = 0; i < 8; i++) begin
      hw_reset({i[0] ^ i[1], i[2:0]});
      cyc(4);
      bus_rd(PHYC_ADDR_CTRL, d);
      check(d, {9'h000, ctrl});
      check(autox, act[6:5] == 2'h3);
      check(mdxa, exp_mdx());
      r0 = ref_o;
      cyc(1);
      check({ref_o & act[4], ref_o ^ r0}, {1'b0, ~act[4]});
    end
    for (int x = 0; x < 4; x++) begin
      ctrl = {2'(x), 5'h08};
      bus_wr(PHYC_ADDR_CTRL, {9'h000, ctrl});
      cyc(3);
      bus_rd(PHYC_ADDR_CTRL, d);
      check(d, {9'h000, ctrl});
      check(autox, act[6:5] == 2'h3);
      sw_reset(16'h9000);
      check({autox, mdxa}, {act[6:5] == 2'h3, exp_mdx()});
    end
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      anen = v[16];
      // blocked while the inputs move, so no half-changed speed gets captured
      @(posedge clk);
      blk <= 1'b1;
      bus_wr(PHYC_ADDR_CMD, {3'h0, anen, 12'h000});
      anc <= v[9];
      ctrl = {ctrl[6:3], v[15:13]};
      bus_wr(PHYC_ADDR_CTRL, {9'h000, ctrl});
      spd <= (v[1:0] == 2'h3) ? 2'h2 : v[1:0];
      dup <= v[2];
      link <= v[3];
      cab <= 3'(v[6:4] % 5);
      mdix <= v[7];
      ds <= v[8];
      @(posedge clk);
      blk <= (v[12:10] == 3'h0);
      cyc(3);
      bus_rd(PHYC_ADDR_STAT, d);
      check(d, st_exp());
      check(sqe, ctrl[2] && !dup);
      check(polr, !(ctrl[1] && spd == 2'h0));
      check(jab, !ctrl[0] && spd == 2'h0 && !dup);
    end
    anen = 1'b1;
    bus_wr(PHYC_ADDR_CMD, 16'h1000);
    bus_wr(PHYC_ADDR_INTST, 16'h0007);
    @(posedge clk);
    pg <= 1'b1;
    @(posedge clk);
    pg <= 1'b0;
    cyc(2);
    bus_rd(PHYC_ADDR_STAT, d);
    check(d[12], 1'b1);
    bus_rd(PHYC_ADDR_STAT, d);
    check(d[12], 1'b0);
    bus_rd(PHYC_ADDR_INTST, d);
    check({d, irq}, {16'h0001, 1'b0});
    bus_wr(PHYC_ADDR_INTMSK, 16'h0001);
    cyc(2);
    check(irq, 1'b1);
    bus_wr(PHYC_ADDR_INTST, 16'h0001);
    cyc(2);
    check(irq, 1'b0);
    @(posedge clk);
    link <= ~link;
    cyc(3);
    bus_rd(PHYC_ADDR_INTST, d);
    check({d, irq}, {16'h0002, 1'b0});
    bus_wr(PHYC_ADDR_INTST, 16'h0002);
    ds <= 1'b0;
    cyc(2);
    @(posedge clk);
    ds <= 1'b1;
    cyc(3);
    bus_rd(PHYC_ADDR_INTST, d);
    check(d, 16'h0004);
    // macpwr and clock-off written here, but only the reset below makes them count
    @(posedge clk);
    ifm <= 4'h7;
    ctrl = {ctrl[6:5], 2'b10, ctrl[2:0]};
    bus_wr(PHYC_ADDR_CTRL, {9'h000, ctrl});
    bus_wr(PHYC_ADDR_CMD, 16'h1800);
    cyc(4);
    check({macpd, rxstop}, 2'b01);
    sw_reset(16'h9800);
    check(macpd, 1'b1);
    for (int m = 3; m < 6; m += 2) begin
      @(posedge clk);
      ifm <= 4'(m);
      cyc(3);
      check(rxstop, m == 3);
    end
    bus_wr(PHYC_ADDR_CMD, 16'h1000);
    es <= 1'b1;
    cyc(4);
    check({macpd, rxstop}, 2'b10);
    @(posedge clk);
    es <= 1'b0;
    cyc(4);
    check(macpd, 1'b0);
    r0 = ref_o;
    cyc(1);
    check(ref_o | r0, 1'b0);
    bus_wr(5'h05, 16'hffff);
    bus_rd(5'h05, d);
    check(d, 16'h0000);
    bus_rd(PHYC_ADDR_CTRL, d);
    check(d, {9'h000, ctrl});
    bus_rd(PHYC_ADDR_CMD, d);
    check(d, 16'h1000);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
